// File: design/sfa_fuse_ctrl.sv
// Purpose: Security fuse store, ordered programming and configuration
//          memory access gating by fuse state.
// Assumes: Commands arrive decoded from the RF protocol, one per cycle.
// Notes: variantB selects the second device family layout.
`timescale 1ns/1ps

module sfa_fuse_ctrl (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic variantB,
    input wire logic [3:0] fuseImage,
    input wire logic cmdValid,
    input wire sfa_pkg::sfa_cmd_t cmd,
    input wire logic transportPwOk,
    input wire logic writePwOk,
    input wire logic [2:0] writePwSet,
    input wire logic encActive,
    input wire logic userZoneGrant,
    output logic rspValid,
    output sfa_pkg::sfa_rsp_t rsp,
    output logic cfgRdGo,
    output logic cfgWrGo,
    output logic [7:0] cfgAddr,
    output logic userAccessOk,
    output logic configLocked,
    output logic secretsLocked,
    output logic securePersoEn,
    output logic macWriteEn
);

    // Region of a byte address, shared by read and write checks.
    function automatic sfa_pkg::sfa_region_t regionOf(input logic [7:0] a,
                                                      input logic vb);
        logic [7:0] pwOff;
        pwOff = a - sfa_pkg::PW_LO;
        if (a < sfa_pkg::MTA_LO) begin
            regionOf = sfa_pkg::RG_ANTICOL;
        end else if (a < sfa_pkg::MAKER_LO) begin
            regionOf = sfa_pkg::RG_MTA;
        end else if (a < sfa_pkg::HWR_LO) begin
            regionOf = vb ? sfa_pkg::RG_ANTICOL : sfa_pkg::RG_MAKER;
        end else if (a < sfa_pkg::RO_LO) begin
            regionOf = vb ? sfa_pkg::RG_HWR : sfa_pkg::RG_RDONLY;
        end else if (a < sfa_pkg::AC_LO) begin
            regionOf = sfa_pkg::RG_RDONLY;
        end else if (a < sfa_pkg::NCDCR_END && vb) begin
            regionOf = sfa_pkg::RG_NCDCR;
        end else if (a < sfa_pkg::CRY_LO) begin
            regionOf = sfa_pkg::RG_ACCESS;
        end else if (a < sfa_pkg::SECRET_LO) begin
            // Session keys fill the upper half of each crypto row.
            regionOf = a[3] ? sfa_pkg::RG_SKEY : sfa_pkg::RG_CRYPTO;
        end else if (a < sfa_pkg::PW_LO) begin
            regionOf = sfa_pkg::RG_SECRET;
        end else if (a < sfa_pkg::FORB_LO) begin
            regionOf = (pwOff[1:0] == 2'h0) ? sfa_pkg::RG_ATTEMPT
                                             : sfa_pkg::RG_PWD;
        end else begin
            regionOf = sfa_pkg::RG_FORBID;
        end
    endfunction

    sfa_pkg::sfa_state_t state_ff;
    sfa_pkg::sfa_state_t nxt_state;
    logic [3:0] fuse_ff;
    logic [3:0] nxt_fuse;
    logic rspValid_ff;
    sfa_pkg::sfa_rsp_t rsp_ff;
    sfa_pkg::sfa_rsp_t nxt_rsp;
    logic cfgRdGo_ff;
    logic cfgWrGo_ff;
    logic [7:0] cfgAddr_ff;

    // Fuse roles by variant; a fuse is done when its bit reads 0.
    // factory fuse shared by both variant layouts
    wire logic factoryDone = ~fuse_ff[sfa_pkg::FACTORY_LOCK_BIT];
    wire logic step1Done = variantB ? ~fuse_ff[sfa_pkg::B_ENCRYPT_BIT]
                                    : ~fuse_ff[sfa_pkg::A_FABRICATION_BIT];
    wire logic step2Done = variantB ? ~fuse_ff[sfa_pkg::B_SECRET_KEY_BIT]
                                    : ~fuse_ff[sfa_pkg::A_MAKER_CODE_BIT];
    wire logic persoDone = variantB ? ~fuse_ff[sfa_pkg::B_PERSO_BIT]
                                    : ~fuse_ff[sfa_pkg::A_PERSO_BIT];
    wire logic [7:0] fuseByte = {sfa_pkg::RESERVED_BITS, fuse_ff};

    // Nothing is taken on the load edge, so the order checks never see the
    // shipped value in place of the real cells.
    wire logic running = (state_ff == sfa_pkg::ST_RUN);
    wire logic take = ce && cmdValid && running;
    wire logic isFuseParam = (cmd.param == sfa_pkg::PARAM_FUSE);
    wire logic isNormal = (cmd.param == sfa_pkg::PARAM_NORMAL);
    wire logic fuseRead = !cmd.isWrite && isFuseParam
        && cmd.addr == sfa_pkg::ADDR_FUSE_READ && cmd.len == sfa_pkg::LEN_FUSE;
    wire logic fuseWrFmt = cmd.isWrite && isFuseParam
        && cmd.len == sfa_pkg::LEN_FUSE && cmd.data == sfa_pkg::DATA_FUSE;

    wire logic okStep1 = fuseWrFmt && cmd.addr == sfa_pkg::ADDR_FUSE_STEP1
        && factoryDone && !step1Done;
    wire logic okStep2 = fuseWrFmt && cmd.addr == sfa_pkg::ADDR_FUSE_STEP2
        && step1Done && !step2Done;
    wire logic okStep3 = fuseWrFmt && cmd.addr == sfa_pkg::ADDR_FUSE_STEP3
        && step2Done && !persoDone;
    wire logic [1:0] stepBit = (okStep1 || okStep2)
        ? (variantB ? (okStep1 ? 2'h2 : 2'h1) : (okStep1 ? 2'h0 : 2'h1))
        : (variantB ? 2'h0 : 2'h2);
    // No password gates programming: order alone decides, and a skipped
    // step only earns a NAK with the byte untouched.
    wire logic fuseProg = okStep1 || okStep2 || okStep3;
    // programming drives a bit to 0
    wire logic [3:0] clearMask = fuseProg ? (4'h1 << stepBit) : 4'h0;

    wire sfa_pkg::sfa_region_t region = regionOf(cmd.addr, variantB);
    wire logic tpw = transportPwOk;
    // The set index is the eight-byte row inside the password block.
    // write password opens only its own set
    wire logic [7:0] pwOff = cmd.addr - sfa_pkg::PW_LO;
    wire logic ownSet = writePwOk && (pwOff[5:3] == writePwSet);
    // second variant: secrets need encryption once the encrypt fuse is set and die with the key fuse
    wire logic secretPath = tpw && (!variantB || !step1Done || encActive);
    wire logic secretOk = variantB ? (secretPath && !step2Done)
                                   : (tpw && !persoDone);
    wire logic pwdPath = variantB ? (tpw && (step2Done || !step1Done
                                             || encActive))
                                  : tpw;

    logic rdAllow;
    logic wrAllow;
    always_comb begin
        rdAllow = 1'b0;
        wrAllow = 1'b0;
        case (region)
            sfa_pkg::RG_ANTICOL: begin
                rdAllow = 1'b1;
                wrAllow = tpw && (variantB ? !persoDone : !step1Done);
            end
            sfa_pkg::RG_MTA: begin
                rdAllow = 1'b1;
                wrAllow = 1'b1;
            end
            sfa_pkg::RG_MAKER: begin
                rdAllow = 1'b1;
                wrAllow = tpw && !step2Done;
            end
            sfa_pkg::RG_HWR, sfa_pkg::RG_RDONLY: begin
                rdAllow = 1'b1;
            end
            sfa_pkg::RG_NCDCR: begin
                rdAllow = 1'b1;
                wrAllow = tpw && !step2Done;
            end
            sfa_pkg::RG_ACCESS: begin
                rdAllow = 1'b1;
                wrAllow = tpw && !persoDone;
            end
            sfa_pkg::RG_CRYPTO: begin
                rdAllow = 1'b1;
                wrAllow = tpw && (variantB ? !step2Done : !persoDone);
            end
            sfa_pkg::RG_SKEY, sfa_pkg::RG_SECRET: begin
                rdAllow = secretOk;
                wrAllow = secretOk;
            end
            sfa_pkg::RG_PWD: begin
                rdAllow = persoDone ? ownSet : pwdPath;
                wrAllow = persoDone ? ownSet : pwdPath;
            end
            sfa_pkg::RG_ATTEMPT: begin
                rdAllow = 1'b1;
                wrAllow = persoDone ? ownSet : tpw;
            end
            default: begin
                rdAllow = 1'b0;
                wrAllow = 1'b0;
            end
        endcase
    end

    wire logic grantRd = isNormal && !cmd.isWrite && rdAllow;
    wire logic grantWr = isNormal && cmd.isWrite && wrAllow;

    always_comb begin
        nxt_rsp.ack = 1'b0;
        nxt_rsp.status = fuseByte;
        nxt_rsp.data = 8'h00;
        if (fuseRead) begin
            nxt_rsp.ack = 1'b1;
            nxt_rsp.data = fuseByte;
        end else if (fuseProg) begin
            // status shows fuse byte after programming
            nxt_rsp.ack = 1'b1;
            nxt_rsp.status = {sfa_pkg::RESERVED_BITS, fuse_ff & ~clearMask};
        end else if (grantRd || grantWr) begin
            nxt_rsp.ack = 1'b1;
        end
    end

    // bits only ever move toward programmed
    assign nxt_fuse = (state_ff == sfa_pkg::ST_LOAD)
        ? (fuseImage & sfa_pkg::FUSE_RESET)
        : (take ? (fuse_ff & ~clearMask) : fuse_ff);
    always_comb begin
        case (state_ff)
            sfa_pkg::ST_LOAD: begin
                nxt_state = sfa_pkg::ST_RUN;
            end
            sfa_pkg::ST_RUN: begin
                nxt_state = sfa_pkg::ST_RUN;
            end
            default: begin
                // A lost state resumes running; a reload could undo fuses.
                nxt_state = sfa_pkg::ST_RUN;
            end
        endcase
    end

    // Fuse cells are modelled by flops: the shipped value at reset, then
    // the stored image is folded in once, as it cannot be sampled under
    // the asynchronous reset.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= sfa_pkg::ST_LOAD;
            fuse_ff <= sfa_pkg::FUSE_RESET;
        end else if (ce) begin
            state_ff <= nxt_state;
            fuse_ff <= nxt_fuse;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rspValid_ff <= 1'b0;
            rsp_ff <= '0;
            cfgRdGo_ff <= 1'b0;
            cfgWrGo_ff <= 1'b0;
            cfgAddr_ff <= 8'h00;
        end else if (ce) begin
            rspValid_ff <= take;
            cfgRdGo_ff <= take && grantRd;
            cfgWrGo_ff <= take && grantWr;
            // The answer holds between commands for a reader that looks late.
            if (take) begin
                rsp_ff <= nxt_rsp;
                cfgAddr_ff <= cmd.addr;
            end
        end
    end

    assign rspValid = rspValid_ff;
    assign rsp = rsp_ff;
    assign cfgRdGo = cfgRdGo_ff;
    assign cfgWrGo = cfgWrGo_ff;
    assign cfgAddr = cfgAddr_ff;
    // user zones follow their own registers
    assign userAccessOk = userZoneGrant;
    // full lock after the last step
    assign configLocked = step1Done && step2Done && persoDone;
    // Only the second variant has a key fuse; the first never locks these.
    // key fuse kills secrets
    assign secretsLocked = variantB && step2Done;
    assign securePersoEn = !(variantB && step2Done);
    assign macWriteEn = !(variantB && step2Done);

endmodule

// File: include/sfa_pkg.sv
// Purpose: Shared constants and types for the security fuse access block.
// Assumes: Configuration memory is addressed by one byte.
// Notes: Fuse bits read 0 when programmed.
package sfa_pkg;

    localparam logic [7:0] PARAM_NORMAL = 8'h00;
    localparam logic [7:0] PARAM_FUSE = 8'h01;
    localparam logic [7:0] ADDR_FUSE_READ = 8'hff;
    localparam logic [7:0] ADDR_FUSE_STEP1 = 8'h06;
    localparam logic [7:0] ADDR_FUSE_STEP2 = 8'h04;
    localparam logic [7:0] ADDR_FUSE_STEP3 = 8'h00;
    localparam logic [7:0] LEN_FUSE = 8'h00;
    localparam logic [7:0] DATA_FUSE = 8'h00;

    // Security fuse byte: bit positions and shipped value.
    localparam logic [7:0] OFS_SECURITY_FUSE_BYTE = 8'hff;
    localparam logic [3:0] FUSE_RESET = 4'h7;
    localparam logic [3:0] RESERVED_BITS = 4'hf;
    localparam int FACTORY_LOCK_BIT = 3;
    localparam int A_PERSO_BIT = 2;
    localparam int A_MAKER_CODE_BIT = 1;
    localparam int A_FABRICATION_BIT = 0;
    localparam int B_ENCRYPT_BIT = 2;
    localparam int B_SECRET_KEY_BIT = 1;
    localparam int B_PERSO_BIT = 0;

    // Region boundaries of the configuration memory.
    localparam logic [7:0] MTA_LO = 8'h0a;
    localparam logic [7:0] MAKER_LO = 8'h0c;
    localparam logic [7:0] HWR_LO = 8'h0e;
    localparam logic [7:0] RO_LO = 8'h10;
    localparam logic [7:0] AC_LO = 8'h18;
    localparam logic [7:0] NCDCR_END = 8'h20;
    localparam logic [7:0] CRY_LO = 8'h50;
    localparam logic [7:0] SECRET_LO = 8'h90;
    localparam logic [7:0] PW_LO = 8'hb0;
    localparam logic [7:0] FORB_LO = 8'hf0;

    typedef enum logic [3:0] {
        RG_ANTICOL, RG_MTA, RG_MAKER, RG_HWR, RG_RDONLY, RG_NCDCR, RG_ACCESS,
        RG_CRYPTO, RG_SKEY, RG_SECRET, RG_PWD, RG_ATTEMPT, RG_FORBID
    } sfa_region_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01
    } sfa_state_t;

    typedef struct packed {
        logic isWrite;
        logic [7:0] param;
        logic [7:0] addr;
        logic [7:0] len;
        logic [7:0] data;
    } sfa_cmd_t;

    typedef struct packed {
        logic ack;
        logic [7:0] status;
        logic [7:0] data;
    } sfa_rsp_t;

endpackage

// File: tb/sfa_fuse_ctrl_properties.sv
// Purpose: Port-level properties of the fuse access block.
// Assumes: ce is held high while commands flow.
// Notes: Bound to every instance of the fuse controller.
`timescale 1ns/1ps
module sfa_fuse_ctrl_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic cmdValid,
    input wire sfa_pkg::sfa_cmd_t cmd,
    input wire logic userZoneGrant,
    input wire logic rspValid,
    input wire sfa_pkg::sfa_rsp_t rsp,
    input wire logic cfgRdGo,
    input wire logic cfgWrGo,
    input wire logic [7:0] cfgAddr,
    input wire logic userAccessOk,
    input wire logic configLocked,
    input wire logic secretsLocked,
    input wire logic securePersoEn,
    input wire logic macWriteEn
);
    logic ldDone_ff;
    // The edge after reset only loads the fuse image, so no command counts.
    wire take = ce && cmdValid && ldDone_ff;
    wire fuseRd = take && !cmd.isWrite && cmd.param == 8'h01
        && cmd.addr == 8'hff && cmd.len == 8'h00;
    wire lockWr = take && configLocked && cmd.isWrite && cmd.param == 8'h00
        && cmd.addr >= 8'h10 && cmd.addr < 8'hb0;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ldDone_ff <= 1'b0;
        end else if (ce) begin
            ldDone_ff <= 1'b1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_answer; take |=> rspValid; endproperty
    a_answer: assert property (p_answer)
        else $error("command got no answer");
    property p_noSpur; rspValid |-> $past(take); endproperty
    a_noSpur: assert property (p_noSpur)
        else $error("answer without command");
    property p_fuseRd;
        fuseRd |=> rsp.ack && rsp.data[7:3] == 5'h1e && rsp.status == rsp.data;
    endproperty
    a_fuseRd: assert property (p_fuseRd)
        else $error("fuse byte answer wrong");
    property p_goAck;
        (cfgRdGo || cfgWrGo) |-> rspValid && rsp.ack && !(cfgRdGo && cfgWrGo);
    endproperty
    a_goAck: assert property (p_goAck)
        else $error("grant without acknowledged answer");
    property p_nakQuiet; rspValid && !rsp.ack |-> !cfgRdGo && !cfgWrGo;
    endproperty
    a_nakQuiet: assert property (p_nakQuiet)
        else $error("refused access still granted");
    property p_addr; take |=> cfgAddr == $past(cmd.addr); endproperty
    a_addr: assert property (p_addr)
        else $error("address not latched");
    property p_user; userAccessOk == userZoneGrant; endproperty
    a_user: assert property (p_user)
        else $error("user access altered by fuses");
    property p_lockStay; configLocked |=> configLocked; endproperty
    a_lockStay: assert property (p_lockStay)
        else $error("lock released");
    property p_lockWr; lockWr |=> !cfgWrGo; endproperty
    a_lockWr: assert property (p_lockWr)
        else $error("write granted after lock");
    property p_secret; secretsLocked |-> !securePersoEn && !macWriteEn;
    endproperty
    a_secret: assert property (p_secret)
        else $error("secret lock leaves features on");
endmodule
bind sfa_fuse_ctrl sfa_fuse_ctrl_properties u_props (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .cmdValid(cmdValid),
    .cmd(cmd), .userZoneGrant(userZoneGrant), .rspValid(rspValid),
    .rsp(rsp), .cfgRdGo(cfgRdGo), .cfgWrGo(cfgWrGo), .cfgAddr(cfgAddr),
    .userAccessOk(userAccessOk), .configLocked(configLocked),
    .secretsLocked(secretsLocked), .securePersoEn(securePersoEn),
    .macWriteEn(macWriteEn));

// File: tb/sfa_reader_model.sv
// Purpose: Reader that issues configuration zone commands.
// Assumes: One command is taken per enabled edge.
// Notes: Released command lines show the inverse of the last value.
`timescale 1ns/1ps
module sfa_reader_model (
    input wire logic core_clk,
    output logic cmdValid,
    output sfa_pkg::sfa_cmd_t cmd,
    input wire logic rspValid,
    input wire sfa_pkg::sfa_rsp_t rsp
);
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
    end
    task automatic issue(input sfa_pkg::sfa_cmd_t c,
        output sfa_pkg::sfa_rsp_t r, output logic seen);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmd <= c;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        cmd <= ~c;
        // The answer launched at the edge above still stands at this one.
        @(posedge core_clk);
        seen = rspValid;
        r = rsp;
    endtask
endmodule

// File: tb/test_sfa_fuse_ctrl.sv
// Purpose: Self-checking bench for the fuse access block.
// Assumes: ce high, fuse image all unprogrammed; the shipped value sets the factory fuse.
// Notes: Both variants are walked through the full fuse sequence.
`timescale 1ns/1ps
module test_sfa_fuse_ctrl;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic variantB = 1'b0;
    logic transportPwOk = 1'b0;
    logic userZoneGrant = 1'b0;
    logic writePwOk = 1'b0;
    logic [2:0] writePwSet = 3'h0;
    logic encActive = 1'b0;
    logic cmdValid, rspValid, cfgRdGo, cfgWrGo, userAccessOk, seen;
    logic configLocked, secretsLocked, securePersoEn, macWriteEn;
    logic [7:0] cfgAddr;
    sfa_pkg::sfa_cmd_t cmd;
    sfa_pkg::sfa_rsp_t rsp, r;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    always #2.5 core_clk = ~core_clk;
    sfa_fuse_ctrl u_dut (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
        .variantB(variantB), .fuseImage(4'hf), .cmdValid(cmdValid),
        .cmd(cmd), .transportPwOk(transportPwOk), .writePwOk(writePwOk),
        .writePwSet(writePwSet), .encActive(encActive),
        .userZoneGrant(userZoneGrant),
        .rspValid(rspValid), .rsp(rsp), .cfgRdGo(cfgRdGo), .cfgWrGo(cfgWrGo),
        .cfgAddr(cfgAddr), .userAccessOk(userAccessOk),
        .configLocked(configLocked), .secretsLocked(secretsLocked),
        .securePersoEn(securePersoEn), .macWriteEn(macWriteEn));
    sfa_reader_model u_rdr (.core_clk(core_clk), .cmdValid(cmdValid),
        .cmd(cmd), .rspValid(rspValid), .rsp(rsp));
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            miscompares++;
        end
    endtask
    function automatic logic [7:0] fuseExp(input int steps, input logic vb);
        logic [7:0] f;
        f = 8'hf7;
        for (int i = 0; i < steps; i++) begin
            f[vb ? 2 - i : i] = 1'b0;
        end
        return f;
    endfunction
    // Grants expected once all fuses are programmed, in either variant.
    function automatic logic [1:0] lockedExp(input logic [7:0] a,
            input logic wp, input logic [2:0] ws);
        logic [7:0] o;
        logic own;
        logic rd;
        o = a - 8'hb0;
        own = wp && (o[5:3] == ws);
        if (a < 8'h50) begin
            rd = 1'b1;
        end else if (a < 8'h90) begin
            rd = !a[3];
        end else if (a < 8'hb0 || a >= 8'hf0) begin
            rd = 1'b0;
        end else begin
            rd = (a[1:0] == 2'h0) || own;
        end
        return {rd, (a == 8'h0a || a == 8'h0b)
            || (a >= 8'hb0 && a < 8'hf0 && own)};
    endfunction
    task automatic op(input logic w, input logic [7:0] p, input logic [7:0] a);
        u_rdr.issue('{isWrite: w, param: p, addr: a, len: 8'h00,
            data: 8'h00}, r, seen);
        chk("rspValid", 8'h01, {7'h0, seen});
    endtask
    task automatic seq(input logic vb);
        logic [7:0] a;
        logic w;
        logic [1:0] g;
        @(posedge core_clk);
        arst_n <= 1'b0;
        variantB <= vb;
        transportPwOk <= 1'b0;
        writePwOk <= 1'b0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        op(1'b0, 8'h01, 8'hff);
        chk("fuseByte", fuseExp(0, vb), r.data);
        op(1'b1, 8'h01, 8'h04);
        chk("earlyStatus", fuseExp(0, vb), r.status);
        chk("earlyAck", 8'h00, 8'(r.ack));
        op(1'b1, 8'h00, 8'h02);
        chk("noPwWrite", 8'h00, {7'h0, cfgWrGo});
        transportPwOk <= 1'b1;
        op(1'b1, 8'h00, 8'h50);
        chk("cryptoWr", 8'h01, {7'h0, cfgWrGo});
        for (int s = 1; s <= 3; s++) begin
            a = s == 1 ? sfa_pkg::ADDR_FUSE_STEP1 :
                s == 2 ? sfa_pkg::ADDR_FUSE_STEP2 : sfa_pkg::ADDR_FUSE_STEP3;
            op(1'b1, 8'h01, a);
            chk("stepStatus", fuseExp(s, vb), r.status);
            if (s == 1) begin
                op(1'b1, 8'h00, 8'h02);
                chk("anticolWr", {7'h0, vb}, {7'h0, cfgWrGo});
                op(1'b0, 8'h00, 8'h90);
                chk("secretRd", 8'(!vb), 8'(cfgRdGo));
                encActive <= 1'b1;
                op(1'b0, 8'h00, 8'h90);
                chk("secretEnc", 8'h01, 8'(cfgRdGo));
                encActive <= 1'b0;
            end
        end
        chk("secretLock", {7'h0, vb}, {7'h0, secretsLocked});
        chk("cfgLocked", 8'h01, {7'h0, configLocked});
        op(1'b1, 8'h00, 8'h50);
        chk("lockedWr", 8'h00, {7'h0, cfgWrGo});
        op(1'b1, 8'h01, sfa_pkg::ADDR_FUSE_STEP1);
        chk("refuse", fuseExp(3, vb), r.status);
        writePwOk <= 1'b1;
        writePwSet <= 3'h2;
        op(1'b1, 8'h00, 8'hc4);
        chk("ownPac", 8'h01, 8'(cfgWrGo));
        op(1'b1, 8'h00, 8'hbc);
        chk("otherPwd", 8'h00, 8'(cfgWrGo));
        repeat (8) begin
            transportPwOk <= 1'($urandom);
            userZoneGrant <= 1'($urandom);
            writePwOk <= 1'($urandom);
            writePwSet <= 3'($urandom);
            op(1'b0, 8'h00, 8'h10 + 8'($urandom_range(7)));
            chk("roRead", 8'h01, {7'h0, cfgRdGo});
            chk("userOk", 8'(userZoneGrant), 8'(userAccessOk));
            a = 8'($urandom);
            w = 1'($urandom);
            g = lockedExp(a, writePwOk, writePwSet);
            op(w, 8'h00, a);
            chk("lockRd", 8'(g[1] && !w), 8'(cfgRdGo));
            chk("lockWr", 8'(g[0] && w), 8'(cfgWrGo));
            chk("lockAck", 8'(w ? g[0] : g[1]), 8'(r.ack));
        end
        $display("test variant %0d done", vb);
    endtask
    initial begin
        void'($urandom(32'hae75d4ce));
        seq(1'b0);
        seq(1'b1);
        stop_test();
    end
endmodule
